// >>> pkg/pmx_map.svh
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

// =============================================================
// Register offsets
`define PMX_A_DIR 8'h00
`define PMX_A_FSEL 8'h04
`define PMX_B_DIR 8'h08
`define PMX_B_FSEL 8'h0c
`define PMX_C_DIR 8'h10
`define PMX_C_FSEL 8'h14
`define PMX_S_DIR 8'h18
`define PMX_S_FSEL 8'h1c
`define PMX_D_DIR 8'h20
`define PMX_D_FSEL 8'h24
`define PMX_M_DIR 8'h28
`define PMX_M_FSEL 8'h2c
`define PMX_PIN_IN 8'h30
`define PMX_STATUS 8'h34
// Address bit that selects the output latches; reads there return the pins.
`define PMX_LAT 8'h80

// =============================================================
// Reset values: every pin is a port input after reset.
`define PMX_DIR_RST 8'hff
`define PMX_FSEL_RST 8'h00

// =============================================================
// Bit positions
`define PMX_A_REQ0 3
`define PMX_A_REQ1 4
`define PMX_A_TOUT 1
`define PMX_C_TC 1
`define PMX_M_WAIT 0
`define PMX_M_CLK 1
`define PMX_M_HACK 2
`define PMX_M_HREQ 3
`define PMX_M_REF 4

`endif

// >>> pkg/pmx_pkg.sv
package pmx_pkg;
  typedef enum logic [1:0] {
    PMX_BUS_OWN,
    PMX_BUS_DRAIN,
    PMX_BUS_HELD
  } pmx_hold_e;
  typedef logic [7:0] pmx_byte_t;
endpackage

// >>> verilog/pmx_sync.sv
`timescale 1ns/1ps
module pmx_sync #(
  parameter int W = 2
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= D;
      s2_reg <= s1_reg;
    end
  end
  assign Q = s2_reg;
endmodule

// >>> verilog/pmx_pin_cell.sv
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter int W = 5
) (
  input wire logic [W-1:0] DIR_IN,
  input wire logic [W-1:0] FSEL,
  input wire logic [W-1:0] PORT_OUT,
  input wire logic [W-1:0] CTRL_OUT,
  input wire logic [W-1:0] CTRL_OE,
  output logic [W-1:0] PIN_O,
  output logic [W-1:0] PIN_OE
);
  // =============================================================
  // Per-bit mux: control use takes the peripheral drive, port use the latch.
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign PIN_O[i] = FSEL[i] ? CTRL_OUT[i] : PORT_OUT[i];
      assign PIN_OE[i] = FSEL[i] ? CTRL_OE[i] : ~DIR_IN[i];
    end
  endgenerate
endmodule

// >>> verilog/pmx_top.sv
`timescale 1ns/1ps
`include "pmx_map.svh"
module pmx_top
  import pmx_pkg::*;
#(
  parameter int AW = 5,
  parameter int BW = 2,
  parameter int SW = 6,
  parameter int NW = 4,
  parameter int DW = 2,
  parameter int MW = 5
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [AW-1:0] PA_I,
  output logic [AW-1:0] PA_O,
  output logic [AW-1:0] PA_OE,
  input wire logic [BW-1:0] PB_I,
  output logic [BW-1:0] PB_O,
  output logic [BW-1:0] PB_OE,
  input wire logic [1:0] PC_I,
  output logic [1:0] PC_O,
  output logic [1:0] PC_OE,
  input wire logic [SW-1:0] PS_I,
  output logic [SW-1:0] PS_O,
  output logic [SW-1:0] PS_OE,
  input wire logic [NW-1:0] PN_I,
  input wire logic [DW-1:0] PD_I,
  output logic [DW-1:0] PD_O,
  output logic [DW-1:0] PD_OE,
  input wire logic [MW-1:0] PM_I,
  output logic [MW-1:0] PM_O,
  output logic [MW-1:0] PM_OE,
  input wire logic TIMER0_PULSE_OUT,
  output logic [AW-1:0] PORT_A_CTRL_IN,
  output logic [BW-1:0] PORT_B_CTRL_IN,
  output logic EXT_IRQ_D0,
  output logic NMI_REQ,
  input wire logic [SW-1:0] SERIAL_OUT,
  input wire logic [SW-1:0] SERIAL_OE,
  output logic [SW-1:0] SERIAL_IN,
  output logic [NW-1:0] ANALOG_IN,
  output logic [1:0] DMA_REQ_PEND,
  output logic DMA_GRANT_CH,
  input wire logic DMA_START,
  input wire logic DMA_EXT_MEM,
  input wire logic DMA_END,
  input wire logic BUS_CYCLE_ACTIVE,
  input wire logic REFRESH_DUE,
  output logic WAIT_INSERT,
  output logic BUS_FLOAT
);
  // =============================================================
  // Registers
  pmx_byte_t a_dir_reg, a_dir_next, a_fsel_reg, a_fsel_next;
  pmx_byte_t b_dir_reg, b_dir_next, b_fsel_reg, b_fsel_next;
  pmx_byte_t c_dir_reg, c_dir_next, c_fsel_reg, c_fsel_next;
  pmx_byte_t s_dir_reg, s_dir_next, s_fsel_reg, s_fsel_next;
  pmx_byte_t d_dir_reg, d_dir_next, d_fsel_reg, d_fsel_next;
  pmx_byte_t m_dir_reg, m_dir_next, m_fsel_reg, m_fsel_next;
  pmx_byte_t pa_lat_reg, pa_lat_next, pb_lat_reg, pb_lat_next;
  pmx_byte_t pc_lat_reg, pc_lat_next, ps_lat_reg, ps_lat_next;
  pmx_byte_t pd_lat_reg, pd_lat_next, pm_lat_reg, pm_lat_next;
  pmx_byte_t rdata_reg, rdata_next;

  function automatic pmx_byte_t pad(input logic [7:0] v, input int w);
    pmx_byte_t m;
    m = 8'hff >> (8 - w);
    return v & m;
  endfunction

  // Latch offsets write the output latch and read the pins, keeping the map compact.
  logic lat_sel;
  assign lat_sel = ADDR[7];

  always_comb begin
    a_dir_next = a_dir_reg;
    a_fsel_next = a_fsel_reg;
    b_dir_next = b_dir_reg;
    b_fsel_next = b_fsel_reg;
    c_dir_next = c_dir_reg;
    c_fsel_next = c_fsel_reg;
    s_dir_next = s_dir_reg;
    s_fsel_next = s_fsel_reg;
    d_dir_next = d_dir_reg;
    d_fsel_next = d_fsel_reg;
    m_dir_next = m_dir_reg;
    m_fsel_next = m_fsel_reg;
    pa_lat_next = pa_lat_reg;
    pb_lat_next = pb_lat_reg;
    pc_lat_next = pc_lat_reg;
    ps_lat_next = ps_lat_reg;
    pd_lat_next = pd_lat_reg;
    pm_lat_next = pm_lat_reg;
    if (WR && lat_sel) begin
      case ({1'b0, ADDR[6:0]})
        `PMX_A_DIR: pa_lat_next = pad(WDATA, AW);
        `PMX_B_DIR: pb_lat_next = pad(WDATA, BW);
        `PMX_C_DIR: pc_lat_next = pad(WDATA, 2);
        `PMX_S_DIR: ps_lat_next = pad(WDATA, SW);
        `PMX_D_DIR: pd_lat_next = pad(WDATA, DW);
        `PMX_M_DIR: pm_lat_next = pad(WDATA, MW);
        default: ;
      endcase
    end else if (WR) begin
      case (ADDR)
        `PMX_A_DIR: a_dir_next = pad(WDATA, AW);
        `PMX_A_FSEL: a_fsel_next = pad(WDATA, AW);
        `PMX_B_DIR: b_dir_next = pad(WDATA, BW);
        `PMX_B_FSEL: b_fsel_next = pad(WDATA, BW);
        // Pin 0 of port C is input only, so its direction bit sticks at input.
        `PMX_C_DIR: c_dir_next = pad(WDATA, 2) | 8'h01;
        `PMX_C_FSEL: c_fsel_next = pad(WDATA, 2) & 8'h02;
        `PMX_S_DIR: s_dir_next = pad(WDATA, SW);
        `PMX_S_FSEL: s_fsel_next = pad(WDATA, SW);
        `PMX_D_DIR: d_dir_next = pad(WDATA, DW);
        `PMX_D_FSEL: d_fsel_next = pad(WDATA, DW);
        `PMX_M_DIR: m_dir_next = pad(WDATA, MW);
        `PMX_M_FSEL: m_fsel_next = pad(WDATA, MW);
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      a_dir_reg <= pad(`PMX_DIR_RST, AW);
      b_dir_reg <= pad(`PMX_DIR_RST, BW);
      c_dir_reg <= pad(`PMX_DIR_RST, 2);
      s_dir_reg <= pad(`PMX_DIR_RST, SW);
      d_dir_reg <= pad(`PMX_DIR_RST, DW);
      m_dir_reg <= pad(`PMX_DIR_RST, MW);
      a_fsel_reg <= `PMX_FSEL_RST;
      b_fsel_reg <= `PMX_FSEL_RST;
      c_fsel_reg <= `PMX_FSEL_RST;
      s_fsel_reg <= `PMX_FSEL_RST;
      d_fsel_reg <= `PMX_FSEL_RST;
      m_fsel_reg <= `PMX_FSEL_RST;
      pa_lat_reg <= 8'h00;
      pb_lat_reg <= 8'h00;
      pc_lat_reg <= 8'h00;
      ps_lat_reg <= 8'h00;
      pd_lat_reg <= 8'h00;
      pm_lat_reg <= 8'h00;
    end else begin
      a_dir_reg <= a_dir_next;
      b_dir_reg <= b_dir_next;
      c_dir_reg <= c_dir_next;
      s_dir_reg <= s_dir_next;
      d_dir_reg <= d_dir_next;
      m_dir_reg <= m_dir_next;
      a_fsel_reg <= a_fsel_next;
      b_fsel_reg <= b_fsel_next;
      c_fsel_reg <= c_fsel_next;
      s_fsel_reg <= s_fsel_next;
      d_fsel_reg <= d_fsel_next;
      m_fsel_reg <= m_fsel_next;
      pa_lat_reg <= pa_lat_next;
      pb_lat_reg <= pb_lat_next;
      pc_lat_reg <= pc_lat_next;
      ps_lat_reg <= ps_lat_next;
      pd_lat_reg <= pd_lat_next;
      pm_lat_reg <= pm_lat_next;
    end
  end

  // =============================================================
  // Synchronizers for the asynchronous wait and hold request pins
  logic [1:0] async_raw;
  logic [1:0] async_sync;
  assign async_raw = {PM_I[`PMX_M_HREQ] & m_fsel_reg[`PMX_M_HREQ],
                      PM_I[`PMX_M_WAIT] & m_fsel_reg[`PMX_M_WAIT]};
  pmx_sync #(.W(2)) u_sync (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .D(async_raw),
    .Q(async_sync)
  );
  assign WAIT_INSERT = async_sync[0];

  // =============================================================
  // DMA requests, acknowledges, terminal count
  // Requests are level inputs held by the requester until acknowledged.
  logic [1:0] dreq_reg, dreq_next;
  logic [1:0] dack_reg, dack_next;
  logic grant_reg, grant_next;
  logic tc_reg, tc_next;
  logic nmi_prev_reg, nmi_prev_next;

  always_comb begin
    dreq_next[0] = PA_I[`PMX_A_REQ0] & a_fsel_reg[`PMX_A_REQ0];
    dreq_next[1] = PA_I[`PMX_A_REQ1] & a_fsel_reg[`PMX_A_REQ1];
    grant_next = grant_reg;
    dack_next = dack_reg;
    if (DMA_START) begin
      grant_next = !dreq_reg[0];
      // Internal-only transfers leave both acknowledges idle.
      dack_next = DMA_EXT_MEM ? (dreq_reg[0] ? 2'b01 : {dreq_reg[1], 1'b0}) : 2'b00;
    end else if (DMA_END) begin
      dack_next = 2'b00;
    end
    tc_next = DMA_END;
    nmi_prev_next = PC_I[0];
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dreq_reg <= 2'b00;
      dack_reg <= 2'b00;
      grant_reg <= 1'b0;
      tc_reg <= 1'b0;
      nmi_prev_reg <= 1'b0;
    end else begin
      dreq_reg <= dreq_next;
      dack_reg <= dack_next;
      grant_reg <= grant_next;
      tc_reg <= tc_next;
      nmi_prev_reg <= nmi_prev_next;
    end
  end
  assign DMA_REQ_PEND = dreq_reg;
  assign DMA_GRANT_CH = grant_reg;
  assign NMI_REQ = PC_I[0] & ~nmi_prev_reg;

  // =============================================================
  // Bus hold sequencing
  pmx_hold_e hold_reg, hold_next;
  logic hreq;
  assign hreq = async_sync[1];

  always_comb begin
    hold_next = hold_reg;
    case (hold_reg)
      PMX_BUS_OWN: if (hreq) hold_next = BUS_CYCLE_ACTIVE ? PMX_BUS_DRAIN : PMX_BUS_HELD;
      PMX_BUS_DRAIN: if (!BUS_CYCLE_ACTIVE) hold_next = PMX_BUS_HELD;
      PMX_BUS_HELD: if (!hreq) hold_next = PMX_BUS_OWN;
      default: hold_next = PMX_BUS_OWN;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_reg <= PMX_BUS_OWN;
    end else begin
      hold_reg <= hold_next;
    end
  end
  assign BUS_FLOAT = (hold_reg == PMX_BUS_HELD);

  // =============================================================
  // Pin multiplexers
  logic [MW-1:0] m_ctrl_o, m_ctrl_oe;
  always_comb begin
    m_ctrl_o = '0;
    m_ctrl_oe = '0;
    m_ctrl_o[`PMX_M_CLK] = CLK;
    m_ctrl_oe[`PMX_M_CLK] = 1'b1;
    // The acknowledge pin is active low.
    m_ctrl_o[`PMX_M_HACK] = !BUS_FLOAT;
    m_ctrl_oe[`PMX_M_HACK] = 1'b1;
    m_ctrl_o[`PMX_M_REF] = BUS_FLOAT & REFRESH_DUE;
    m_ctrl_oe[`PMX_M_REF] = 1'b1;
  end

  logic [AW-1:0] a_ctrl_o, a_ctrl_oe;
  always_comb begin
    a_ctrl_o = '0;
    a_ctrl_oe = '0;
    a_ctrl_o[`PMX_A_TOUT] = TIMER0_PULSE_OUT;
    a_ctrl_oe[`PMX_A_TOUT] = 1'b1;
  end

  pmx_pin_cell #(.W(AW)) u_pa (.DIR_IN(a_dir_reg[AW-1:0]), .FSEL(a_fsel_reg[AW-1:0]),
    .PORT_OUT(pa_lat_reg[AW-1:0]), .CTRL_OUT(a_ctrl_o), .CTRL_OE(a_ctrl_oe),
    .PIN_O(PA_O), .PIN_OE(PA_OE));
  pmx_pin_cell #(.W(BW)) u_pb (.DIR_IN(b_dir_reg[BW-1:0]), .FSEL(b_fsel_reg[BW-1:0]),
    .PORT_OUT(pb_lat_reg[BW-1:0]), .CTRL_OUT('0), .CTRL_OE('0),
    .PIN_O(PB_O), .PIN_OE(PB_OE));
  pmx_pin_cell #(.W(2)) u_pc (.DIR_IN(c_dir_reg[1:0]), .FSEL(c_fsel_reg[1:0]),
    .PORT_OUT(pc_lat_reg[1:0]), .CTRL_OUT({tc_reg, 1'b0}), .CTRL_OE(2'b10),
    .PIN_O(PC_O), .PIN_OE(PC_OE));
  pmx_pin_cell #(.W(SW)) u_ps (.DIR_IN(s_dir_reg[SW-1:0]), .FSEL(s_fsel_reg[SW-1:0]),
    .PORT_OUT(ps_lat_reg[SW-1:0]), .CTRL_OUT(SERIAL_OUT), .CTRL_OE(SERIAL_OE),
    .PIN_O(PS_O), .PIN_OE(PS_OE));
  pmx_pin_cell #(.W(DW)) u_pd (.DIR_IN(d_dir_reg[DW-1:0]), .FSEL(d_fsel_reg[DW-1:0]),
    .PORT_OUT(pd_lat_reg[DW-1:0]), .CTRL_OUT(~dack_reg), .CTRL_OE('1),
    .PIN_O(PD_O), .PIN_OE(PD_OE));
  pmx_pin_cell #(.W(MW)) u_pm (.DIR_IN(m_dir_reg[MW-1:0]), .FSEL(m_fsel_reg[MW-1:0]),
    .PORT_OUT(pm_lat_reg[MW-1:0]), .CTRL_OUT(m_ctrl_o), .CTRL_OE(m_ctrl_oe),
    .PIN_O(PM_O), .PIN_OE(PM_OE));

  assign PORT_A_CTRL_IN = PA_I & a_fsel_reg[AW-1:0];
  assign PORT_B_CTRL_IN = PB_I & b_fsel_reg[BW-1:0];
  assign EXT_IRQ_D0 = PC_I[1] & c_fsel_reg[1];
  assign SERIAL_IN = PS_I & s_fsel_reg[SW-1:0];
  assign ANALOG_IN = PN_I;

  // =============================================================
  // Read port
  always_comb begin
    rdata_next = 8'h00;
    if (RD) begin
      case (ADDR)
        `PMX_A_DIR: rdata_next = a_dir_reg;
        `PMX_A_FSEL: rdata_next = a_fsel_reg;
        `PMX_B_DIR: rdata_next = b_dir_reg;
        `PMX_B_FSEL: rdata_next = b_fsel_reg;
        `PMX_C_DIR: rdata_next = c_dir_reg;
        `PMX_C_FSEL: rdata_next = c_fsel_reg;
        `PMX_S_DIR: rdata_next = s_dir_reg;
        `PMX_S_FSEL: rdata_next = s_fsel_reg;
        `PMX_D_DIR: rdata_next = d_dir_reg;
        `PMX_D_FSEL: rdata_next = d_fsel_reg;
        `PMX_M_DIR: rdata_next = m_dir_reg;
        `PMX_M_FSEL: rdata_next = m_fsel_reg;
        `PMX_PIN_IN: rdata_next = {4'h0, PN_I};
        `PMX_STATUS: rdata_next = {3'h0, tc_reg, BUS_FLOAT, grant_reg, dack_reg};
        `PMX_LAT | `PMX_A_DIR: rdata_next = 8'(PA_I);
        `PMX_LAT | `PMX_B_DIR: rdata_next = 8'(PB_I);
        `PMX_LAT | `PMX_C_DIR: rdata_next = 8'(PC_I);
        `PMX_LAT | `PMX_S_DIR: rdata_next = 8'(PS_I);
        `PMX_LAT | `PMX_D_DIR: rdata_next = 8'(PD_I);
        `PMX_LAT | `PMX_M_DIR: rdata_next = 8'(PM_I);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign RDATA = rdata_reg;
endmodule

// >>> tb/pmx_chk_sva.sv
`timescale 1ns/1ps
// =============================================================
// Port-level checks of the pin multiplexer and its handshakes.
module pmx_chk_sva #(
  parameter int AW = 5,
  parameter int NW = 4,
  parameter int DW = 2,
  parameter int MW = 5
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [AW-1:0] PA_I,
  input wire logic [1:0] PC_I,
  input wire logic [1:0] PC_O,
  input wire logic [1:0] PC_OE,
  input wire logic [NW-1:0] PN_I,
  input wire logic [DW-1:0] PD_O,
  input wire logic [DW-1:0] PD_OE,
  input wire logic [MW-1:0] PM_I,
  input wire logic [MW-1:0] PM_O,
  input wire logic [MW-1:0] PM_OE,
  input wire logic [NW-1:0] ANALOG_IN,
  input wire logic NMI_REQ,
  input wire logic [1:0] DMA_REQ_PEND,
  input wire logic DMA_GRANT_CH,
  input wire logic DMA_START,
  input wire logic DMA_EXT_MEM,
  input wire logic DMA_END,
  input wire logic BUS_CYCLE_ACTIVE,
  input wire logic WAIT_INSERT,
  input wire logic BUS_FLOAT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  chk_analog_mirror: assert property (ANALOG_IN == PN_I)
    else $error("analog inputs not mirrored");
  chk_nmi_edge: assert property ($past(ARST_N) |-> NMI_REQ == (PC_I[0] && !$past(PC_I[0])))
    else $error("nmi request not tied to a rising edge");
  chk_req_sample: assert property ((DMA_REQ_PEND & ~$past(PA_I[4:3])) == 2'h0)
    else $error("dma request pending without a sampled pin");
  chk_grant_prio: assert property (DMA_START && DMA_REQ_PEND != 2'h0 |=>
    DMA_GRANT_CH == !$past(DMA_REQ_PEND[0])) else $error("wrong dma channel granted");
  chk_ack_start: assert property (DMA_START && DMA_EXT_MEM && PD_OE == 2'h3 |=>
    PD_O != 2'h3) else $error("no acknowledge after external transfer start");
  chk_ack_intmem: assert property (DMA_START && !DMA_EXT_MEM && PD_O == 2'h3 &&
    PD_OE == 2'h3 |=> PD_O == 2'h3) else $error("acknowledge on internal transfer");
  chk_tc_pulse: assert property (DMA_END && PC_OE[1] |=> PC_O[1] ##1
    (!PC_O[1] || $past(DMA_END))) else $error("terminal count not one clock");
  chk_wait_sync: assert property (WAIT_INSERT |-> $past(PM_I[0], 2))
    else $error("wait inserted without synchronized input");
  chk_hold_float: assert property ((PM_I[3] && !BUS_CYCLE_ACTIVE && PM_OE[2]) [*4] |->
    BUS_FLOAT) else $error("bus not floated on idle hold request");
  chk_hack_level: assert property (PM_OE[2] |-> PM_O[2] == !BUS_FLOAT)
    else $error("hold acknowledge disagrees with float");
  cover property (DMA_START && DMA_REQ_PEND == 2'h3);
  cover property ($rose(BUS_FLOAT));
  cover property ($rose(WAIT_INSERT));
endmodule

bind pmx_top pmx_chk_sva #(.AW(AW), .NW(NW), .DW(DW), .MW(MW)) u_chk (.CLK(CLK),
  .ARST_N(ARST_N), .PA_I(PA_I), .PC_I(PC_I), .PC_O(PC_O), .PC_OE(PC_OE), .PN_I(PN_I),
  .PD_O(PD_O), .PD_OE(PD_OE), .PM_I(PM_I), .PM_O(PM_O), .PM_OE(PM_OE),
  .ANALOG_IN(ANALOG_IN), .NMI_REQ(NMI_REQ), .DMA_REQ_PEND(DMA_REQ_PEND),
  .DMA_GRANT_CH(DMA_GRANT_CH), .DMA_START(DMA_START), .DMA_EXT_MEM(DMA_EXT_MEM),
  .DMA_END(DMA_END), .BUS_CYCLE_ACTIVE(BUS_CYCLE_ACTIVE), .WAIT_INSERT(WAIT_INSERT),
  .BUS_FLOAT(BUS_FLOAT));

// >>> tb/pmx_far.sv
`timescale 1ns/1ps
// =============================================================
// Far side: two DMA requesters and an external bus master.
// Each keeps its request up until the acknowledge shows, however late.
module pmx_far (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] req_go,
  input wire logic hold_go,
  input wire logic [1:0] ack_n,
  input wire logic hack_n,
  output logic [1:0] req,
  output logic hreq
);
  logic [1:0] req_reg, req_next;
  logic hreq_reg, hreq_next;
  always_comb begin
    req_next = req_go | (req_reg & ack_n);
    hreq_next = hold_go | (hreq_reg & hack_n);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= 2'h0;
      hreq_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      hreq_reg <= hreq_next;
    end
  end
  assign req = req_reg;
  assign hreq = hreq_reg;
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "pmx_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
// =============================================================
// Register access, pin routing, DMA and bus hold sequences.
module tb_top;
  logic CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, TIMER0_PULSE_OUT = 1'b1;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA;
  logic [4:0] PA_I, PA_O, PA_OE, PORT_A_CTRL_IN, PM_I, PM_O, PM_OE;
  logic [1:0] PB_I = 2'h2, PB_O, PB_OE, PC_I = 2'h0, PC_O, PC_OE, PORT_B_CTRL_IN;
  logic [1:0] PD_I = 2'h0, PD_O, PD_OE, DMA_REQ_PEND, req_go = 2'h0, far_req;
  logic [5:0] PS_I = 6'h15, PS_O, PS_OE, SERIAL_OUT = 6'h2a, SERIAL_OE = 6'h3f, SERIAL_IN;
  logic [3:0] PN_I = 4'ha, ANALOG_IN;
  logic [2:0] pa_lo = 3'h5;
  logic EXT_IRQ_D0, NMI_REQ, DMA_GRANT_CH, WAIT_INSERT, BUS_FLOAT, far_hreq;
  logic DMA_START = 1'b0, DMA_EXT_MEM = 1'b0, DMA_END = 1'b0, BUS_CYCLE_ACTIVE = 1'b0;
  logic REFRESH_DUE = 1'b0, wait_in = 1'b0, hold_go = 1'b0;
  logic [7:0] fsel [6] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h24, 8'h2c};
  logic [7:0] fmask [6] = '{8'h1f, 8'h03, 8'h02, 8'h3f, 8'h03, 8'h1f};
  logic [7:0] dmask [6] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  int num_errors = 0, samples_checked = 0, n;
  pmx_top dut (.*);
  pmx_far far (.clk(CLK), .arst_n(ARST_N), .req_go(req_go), .hold_go(hold_go),
    .ack_n(PD_O | ~PD_OE), .hack_n(PM_O[2] | ~PM_OE[2]), .req(far_req), .hreq(far_hreq));
  assign PA_I = {far_req, pa_lo};
  assign PM_I = {1'b0, far_hreq, 2'h0, wait_in};
  initial begin
    forever #4 CLK = ~CLK;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    `CHK("rdata", e, RDATA)
  endtask
  // A transfer event is a one-cycle pulse; outputs are looked at mid-cycle after it.
  task automatic dma(input logic s, input logic x, input logic e);
    @(posedge CLK);
    DMA_START <= s;
    DMA_EXT_MEM <= x;
    DMA_END <= e;
    @(posedge CLK);
    DMA_START <= 1'b0;
    DMA_EXT_MEM <= 1'b0;
    DMA_END <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(`PMX_A_DIR, 8'h1f);
    rd(8'h3c, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(fsel[i], 8'hff);
      rd(fsel[i], fmask[i]);
      wr(fsel[i] - 8'h04, 8'h00);
      rd(fsel[i] - 8'h04, dmask[i]);
    end
    rd(`PMX_PIN_IN, 8'h0a);
    `CHK("tout", 1'b1, PA_O[1])
    `CHK("ctrl_a", 3'h5, PORT_A_CTRL_IN[2:0])
    `CHK("ctrl_b", 2'h2, PORT_B_CTRL_IN)
    `CHK("serial", 6'h2a, PS_O)
    `CHK("pa_oe", 5'h02, PA_OE)
    `CHK("pb_oe", 2'h0, PB_OE)
    `CHK("pc_oe", 2'h2, PC_OE)
    `CHK("ps_oe", 6'h3f, PS_OE)
    `CHK("ser_in", 6'h15, SERIAL_IN)
    `CHK("pd_oe", 2'h3, PD_OE)
    `CHK("pm_oe", 5'h16, PM_OE)
    // The clock pin is looked at away from the edges so the comparison cannot race them.
    #1;
    `CHK("sys_clock_out_lo", 1'b0, PM_O[1])
    #4;
    `CHK("sys_clock_out_hi", 1'b1, PM_O[1])
    @(posedge CLK);
    PC_I <= 2'h3;
    wait_in <= 1'b1;
    tick(0);
    `CHK("nmi", 1'b1, NMI_REQ)
    `CHK("irq_d0", 1'b1, EXT_IRQ_D0)
    tick(1);
    `CHK("nmi_once", 1'b0, NMI_REQ)
    `CHK("wait_early", 1'b0, WAIT_INSERT)
    tick(1);
    `CHK("wait", 1'b1, WAIT_INSERT)
    @(posedge CLK);
    req_go <= 2'h3;
    @(posedge CLK);
    req_go <= 2'h0;
    tick(1);
    `CHK("pend", 2'h3, DMA_REQ_PEND)
    dma(1'b1, 1'b1, 1'b0);
    `CHK("grant", 1'b0, DMA_GRANT_CH)
    `CHK("ack", 2'h2, PD_O)
    tick(3);
    `CHK("ack_held", 2'h2, PD_O)
    dma(1'b0, 1'b0, 1'b1);
    `CHK("tc", 1'b1, PC_O[1])
    `CHK("ack_off", 2'h3, PD_O)
    tick(1);
    `CHK("tc_once", 1'b0, PC_O[1])
    dma(1'b1, 1'b0, 1'b0);
    `CHK("grant1", 1'b1, DMA_GRANT_CH)
    `CHK("no_ack", 2'h3, PD_O)
    @(posedge CLK);
    BUS_CYCLE_ACTIVE <= 1'b1;
    hold_go <= 1'b1;
    @(posedge CLK);
    hold_go <= 1'b0;
    tick(6);
    `CHK("drain", 1'b0, BUS_FLOAT)
    @(posedge CLK);
    BUS_CYCLE_ACTIVE <= 1'b0;
    REFRESH_DUE <= 1'b1;
    for (n = 0; n < 8 && BUS_FLOAT !== 1'b1; n++) tick(1);
    if (BUS_FLOAT !== 1'b1) begin
      num_errors++;
      results();
    end
    `CHK("hack", 1'b0, PM_O[2])
    `CHK("refresh", 1'b1, PM_O[4])
    for (n = 0; n < 10 && BUS_FLOAT !== 1'b0; n++) tick(1);
    `CHK("release", 1'b0, BUS_FLOAT)
    @(posedge CLK);
    hold_go <= 1'b1;
    @(posedge CLK);
    hold_go <= 1'b0;
    tick(3);
    `CHK("idle_hold", 1'b1, BUS_FLOAT)
    wr(`PMX_A_FSEL, 8'h00);
    wr(`PMX_LAT | `PMX_A_DIR, 8'h0b);
    tick(0);
    `CHK("latch", 5'h0b, PA_O)
    `CHK("latch_oe", 5'h1f, PA_OE)
    rd(`PMX_LAT | `PMX_A_DIR, 8'h15);
    results();
  end
endmodule
